// ==== fw_pkg.sv ====
package fw_pkg;
  localparam int unsigned CLK_MHZ = 100;
  // Half bit cell: FM cell 4 us, MFM cell 2 us
  localparam int unsigned FM_HALF_NS = 2000;
  localparam int unsigned MFM_HALF_NS = 1000;
  localparam int unsigned FM_HALF_CYC = (FM_HALF_NS * CLK_MHZ) / 1000;
  localparam int unsigned MFM_HALF_CYC = (MFM_HALF_NS * CLK_MHZ) / 1000;
  localparam int unsigned TIMER_W = 16;
  localparam logic [TIMER_W-1:0] FM_HALF = TIMER_W'(FM_HALF_CYC);
  localparam logic [TIMER_W-1:0] MFM_HALF = TIMER_W'(MFM_HALF_CYC);
  localparam int unsigned FIFO_DEPTH = 16;

  // Control codes from the host stream
  localparam logic [7:0] CODE_CRC = 8'hf7;
  localparam logic [7:0] CODE_SYNC_A = 8'hf5;
  localparam logic [7:0] CODE_SYNC_C = 8'hf6;
  localparam logic [7:0] MARK_INDEX = 8'hfc;
  localparam logic [7:0] MARK_ID = 8'hfe;
  localparam logic [7:0] MARK_DATA = 8'hfb;

  // Recorded special bytes and their missing clock masks
  localparam logic [7:0] SYNC_A = 8'ha1;
  localparam logic [7:0] SYNC_C = 8'hc2;
  localparam logic [7:0] MASK_SYNC_A = 8'h04;
  localparam logic [7:0] MASK_SYNC_C = 8'h08;
  localparam logic [7:0] MASK_FM_INDEX = 8'h28;
  localparam logic [7:0] MASK_FM_ADDR = 8'h38;
  localparam logic [7:0] MASK_NONE = 8'h00;

  localparam logic [7:0] FILL_FM = 8'hff;
  localparam logic [7:0] FILL_MFM = 8'h4e;

  localparam logic [15:0] CRC_PRESET = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [3:0] LAST_HALF = 4'hf;

  typedef enum logic [1:0] {FW_IDLE, FW_WAIT_INDEX, FW_WRITE} fw_state_t;
endpackage

// ==== fw_track_writer.sv ====
`timescale 1ns/1ns
// Operation
// - Sector size codes pass through untouched; only 128 to 1024 byte sectors intended.
// - Code F7 records the two CRC bytes of the current field instead.
// - In double density code F5 records sync A1 with missing clock.
// - In double density code F6 records sync C2 with missing clock.
// - Marks FC index, FE ID, FB data, each sent once in place.
// - ID field holds track, side, sector, length code; 00 is 128, 01 is 256.
// - Writing never depends on an index address mark being present.
// - Gaps 1, 3, 4 may be as short as two bytes.
// - Writer pads with 4E (FF in FM) when the host runs dry; write stops at next index and raises done.

module fw_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  // Ready is a flop so the host side never sees a combinational path
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      in_ready <= 1'b0;
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (clk_en) begin
      count <= next_count;
      in_ready <= (next_count != (AW+1)'(DEPTH));
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (clk_en && push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

module fw_track_writer
  import fw_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic start,
  input wire logic double_density,
  input wire logic index_pulse,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  output logic in_ready,
  output logic write_gate,
  output logic write_data,
  output logic busy,
  output logic underrun,
  output logic command_done_irq
);
  fw_state_t state;
  logic mfm;
  logic [TIMER_W-1:0] timer;
  logic [3:0] half_idx;
  logic [15:0] shreg;
  logic prev_bit;
  logic [15:0] crc;
  logic crc_lo_pend;
  logic [7:0] crc_lo;
  logic last_sync;
  logic idx_s1;
  logic idx_s2;
  logic idx_s3;
  logic idx_level;
  logic idx_edge;
  logic q_valid;
  logic [7:0] q_data;
  logic q_pop;
  logic load;
  logic half_tick;
  logic [7:0] next_byte;
  logic [7:0] next_mask;
  logic [15:0] next_crc;
  logic next_pend;
  logic next_sync;
  logic next_underrun;

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // Clock then data half cells; a set mask bit drops that clock
  function automatic logic [15:0] encode(input logic [7:0] b, input logic [7:0] m,
                                         input logic dd, input logic p);
    logic [15:0] r;
    logic pv;
    r = '0;
    pv = p;
    for (int i = 7; i >= 0; i--) begin
      r[2*i+1] = (dd ? (~pv & ~b[i]) : 1'b1) & ~m[i];
      r[2*i] = b[i];
      pv = b[i];
    end
    return r;
  endfunction

  fw_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .in_valid(in_valid),
    .in_data(in_data),
    .in_ready(in_ready),
    .out_valid(q_valid),
    .out_data(q_data),
    .out_ready(q_pop)
  );

  // Index pin is asynchronous to clk; level accepted once stages 2 and 3 agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_s1 <= 1'b0;
      idx_s2 <= 1'b0;
      idx_s3 <= 1'b0;
      idx_level <= 1'b0;
    end else if (clk_en) begin
      idx_s1 <= index_pulse;
      idx_s2 <= idx_s1;
      idx_s3 <= idx_s2;
      if (idx_s2 == idx_s3) begin
        idx_level <= idx_s3;
      end
    end
  end

  assign idx_edge = idx_s2 & idx_s3 & ~idx_level;
  assign half_tick = (state == FW_WRITE) && (timer == '0);
  assign load = half_tick && (half_idx == LAST_HALF);
  assign q_pop = load && !crc_lo_pend && q_valid;

  // Byte selection; no check of sector size, gap length or mark order is made
  always_comb begin
    next_byte = q_data;
    next_mask = MASK_NONE;
    next_crc = crc_byte(crc, q_data);
    next_pend = 1'b0;
    next_sync = 1'b0;
    next_underrun = 1'b0;
    if (crc_lo_pend) begin
      next_byte = crc_lo;
      next_crc = crc;
    end else if (!q_valid) begin
      // Host fell behind: keep the track coherent with gap fill
      next_byte = mfm ? FILL_MFM : FILL_FM;
      next_crc = crc;
      next_underrun = 1'b1;
    end else begin
      case (q_data)
        CODE_CRC: begin
          next_byte = crc[15:8];
          next_crc = crc;
          next_pend = 1'b1;
        end
        CODE_SYNC_A: begin
          if (mfm) begin
            next_byte = SYNC_A;
            next_mask = MASK_SYNC_A;
            next_sync = 1'b1;
            next_crc = crc_byte(last_sync ? crc : CRC_PRESET, SYNC_A);
          end
        end
        CODE_SYNC_C: begin
          if (mfm) begin
            next_byte = SYNC_C;
            next_mask = MASK_SYNC_C;
            next_crc = crc;
          end
        end
        MARK_INDEX, MARK_ID, MARK_DATA: begin
          if (!mfm) begin // FM marks carry their own clock pattern and restart the CRC
            next_mask = (q_data == MARK_INDEX) ? MASK_FM_INDEX : MASK_FM_ADDR;
            next_crc = crc_byte(CRC_PRESET, q_data);
          end
        end
        default: begin
          next_byte = q_data;
        end
      endcase
    end
  end

  // Command sequencing: start arms, index opens and closes the write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= FW_IDLE;
      mfm <= 1'b0;
      busy <= 1'b0;
      write_gate <= 1'b0;
      command_done_irq <= 1'b0;
    end else if (clk_en) begin
      case (state)
        FW_IDLE: begin
          if (start) begin
            state <= FW_WAIT_INDEX;
            mfm <= double_density;
            busy <= 1'b1;
            command_done_irq <= 1'b0;
          end
        end
        FW_WAIT_INDEX: begin
          // Only the index pulse is used, never a recorded index mark
          if (idx_edge) begin
            state <= FW_WRITE;
          end
        end
        FW_WRITE: begin
          if (idx_edge) begin
            state <= FW_IDLE;
            busy <= 1'b0;
            write_gate <= 1'b0;
            command_done_irq <= 1'b1;
          end else if (load) begin
            write_gate <= 1'b1;
          end
        end
        default: begin
          state <= FW_IDLE;
        end
      endcase
    end
  end

  // Half cell timer; entering the write forces an immediate byte load
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer <= '0;
      half_idx <= LAST_HALF;
    end else if (clk_en) begin
      if (state != FW_WRITE) begin
        timer <= '0;
        half_idx <= LAST_HALF;
      end else if (half_tick) begin
        timer <= (mfm ? MFM_HALF : FM_HALF) - 1'b1;
        half_idx <= half_idx + 1'b1;
      end else begin
        timer <= timer - 1'b1;
      end
    end
  end

  // Serialiser and CRC; the gap lengths are whatever the host streams
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shreg <= '0;
      write_data <= 1'b0;
      prev_bit <= 1'b0;
      crc <= CRC_PRESET;
      crc_lo_pend <= 1'b0;
      crc_lo <= '0;
      last_sync <= 1'b0;
      underrun <= 1'b0;
    end else if (clk_en) begin
      if (state == FW_IDLE && start) begin
        crc <= CRC_PRESET;
        crc_lo_pend <= 1'b0;
        last_sync <= 1'b0;
        underrun <= 1'b0;
        prev_bit <= 1'b0;
      end
      if (state != FW_WRITE) begin
        write_data <= 1'b0;
      end else if (load) begin
        shreg <= {encode(next_byte, next_mask, mfm, prev_bit) << 1};
        write_data <= encode(next_byte, next_mask, mfm, prev_bit) >> 15 != 16'h0000;
        prev_bit <= next_byte[0];
        crc <= next_crc;
        crc_lo_pend <= next_pend;
        crc_lo <= crc[7:0];
        last_sync <= next_sync;
        if (next_underrun) begin
          underrun <= 1'b1;
        end
      end else if (half_tick) begin
        write_data <= shreg[15];
        shreg <= {shreg[14:0], 1'b0};
      end
    end
  end
endmodule

// ==== fw_sva.sv ====
`timescale 1ns/1ns
module fw_sva
  import fw_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic start,
  input wire logic double_density,
  input wire logic index_pulse,
  input wire logic write_gate,
  input wire logic write_data,
  input wire logic busy,
  input wire logic underrun,
  input wire logic command_done_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic dd_q;
  int unsigned cyc;
  int unsigned h;
  logic [7:0] age;
  assign h = dd_q ? MFM_HALF_CYC : FM_HALF_CYC;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) dd_q <= 1'b0;
    else if (start && !busy && clk_en) dd_q <= double_density;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cyc <= 0;
    else if (!write_gate) cyc <= 0;
    else cyc <= cyc + 1;
  end
  // Saturates so a long idle spell never wraps into a false recent index
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) age <= 8'hff;
    else if (index_pulse) age <= 8'h00;
    else if (age != 8'hff) age <= age + 8'h01;
  end
  sequence go_s;
    start && !busy && clk_en;
  endsequence
  sequence end_s;
    !write_gate && command_done_irq ##1 !write_data;
  endsequence
  chk_end_order: assert property ($fell(busy) |-> end_s)
    else $error("write end out of order");
  chk_end_index: assert property ($fell(busy) |-> age < 8'h08)
    else $error("write ended away from index");
  chk_gate_index: assert property ($rose(write_gate) |-> age < 8'h08)
    else $error("write began away from index");
  chk_start_busy: assert property (go_s |=> busy && !command_done_irq && !underrun)
    else $error("start not taken");
  chk_irq_hold: assert property (command_done_irq && !start |=> command_done_irq)
    else $error("done dropped early");
  chk_irq_idle: assert property (command_done_irq |-> !busy && !write_gate)
    else $error("done while busy");
  chk_gate_busy: assert property (write_gate |-> busy)
    else $error("gate without busy");
  chk_cell_steady: assert property (write_gate && cyc % h != 0 |-> $stable(write_data))
    else $error("cell changed mid period");
  chk_data_quiet: assert property (!write_gate && !$past(write_gate) |-> !write_data)
    else $error("data while gate low");
endmodule

bind fw_track_writer fw_sva #(.DEPTH(DEPTH)) fw_sva_i (
  .clk(clk),
  .rst_n(rst_n),
  .clk_en(clk_en),
  .start(start),
  .double_density(double_density),
  .index_pulse(index_pulse),
  .write_gate(write_gate),
  .write_data(write_data),
  .busy(busy),
  .underrun(underrun),
  .command_done_irq(command_done_irq)
);

// ==== fw_host.sv ====
`timescale 1ns/1ns
module fw_host (
  input wire logic clk,
  input wire logic in_ready,
  output logic in_valid,
  output logic [7:0] in_data
);
  initial begin
    in_valid = 1'b0;
    in_data = 8'h00;
  end
  // Released bus shows the inverse so a stale byte is never mistaken for data
  task automatic send(input logic [7:0] b);
    @(posedge clk);
    in_valid <= 1'b1;
    in_data <= b;
    do @(posedge clk); while (in_ready !== 1'b1);
    in_valid <= 1'b0;
    in_data <= ~b;
  endtask
endmodule

// ==== tb.sv ====
`timescale 1ns/1ns
module tb;
  import fw_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, start = 1'b0, dd = 1'b0, idx = 1'b0;
  logic in_valid, in_ready, write_gate, write_data, busy, underrun, done;
  logic [7:0] in_data, lastb;
  logic [15:0] acc;
  logic [7:0] eb[$], em[$];
  int num_errors = 0, checks = 0, cyc = 0;
  initial forever #5 clk = ~clk;
  fw_host fw_host_i (.clk(clk), .in_ready(in_ready), .in_valid(in_valid), .in_data(in_data));
  fw_track_writer fw_track_writer_i (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .start(start),
    .double_density(dd), .index_pulse(idx), .in_valid(in_valid), .in_data(in_data),
    .in_ready(in_ready), .write_gate(write_gate), .write_data(write_data), .busy(busy),
    .underrun(underrun), .command_done_irq(done));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 70000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  function automatic logic [15:0] enc(input logic [7:0] b, m, input logic mfm, p);
    logic [15:0] w;
    for (int i = 7; i >= 0; i--) begin
      w[2*i+1] = (mfm ? !(p | b[i]) : 1'b1) & !m[i];
      w[2*i] = b[i];
      p = b[i];
    end
    return w;
  endfunction
  function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? CRC_POLY : 16'h0000);
    return c;
  endfunction
  // Appends the track bytes that one host byte should become
  task automatic ex(input logic [7:0] b, input logic d);
    logic [7:0] t, m;
    t = b;
    m = 8'h00;
    if (b === CODE_CRC) begin
      eb.push_back(acc[15:8]);
      eb.push_back(acc[7:0]);
      em.push_back(8'h00);
      em.push_back(8'h00);
    end else begin
      if (d && b === CODE_SYNC_A) begin
        t = SYNC_A;
        m = MASK_SYNC_A;
        if (lastb !== CODE_SYNC_A) acc = CRC_PRESET;
      end
      if (d && b === CODE_SYNC_C) begin
        t = SYNC_C;
        m = MASK_SYNC_C;
      end
      if (!d && (b === MARK_INDEX || b === MARK_ID || b === MARK_DATA)) begin
        m = (b === MARK_INDEX) ? MASK_FM_INDEX : MASK_FM_ADDR;
        acc = CRC_PRESET;
      end
      // The C2 sync bytes are left out of the running check value
      if (!(d && b === CODE_SYNC_C)) acc = crc(acc, t);
      eb.push_back(t);
      em.push_back(m);
    end
    lastb = b;
  endtask
  task automatic run_track(input logic d);
    int h, wt;
    logic p;
    logic [15:0] w, e;
    h = d ? MFM_HALF_CYC : FM_HALF_CYC;
    p = 1'b0;
    @(posedge clk) start <= 1'b1;
    dd <= d;
    @(posedge clk) start <= 1'b0;
    idx <= 1'b1;
    #1 chk(done, 1'b0);
    for (int i = 0; i < 50 && write_gate !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk) idx <= 1'b0;
    wt = h / 2 - 1;
    foreach (eb[k]) begin
      for (int j = 15; j >= 0; j--) begin
        repeat (wt) @(posedge clk);
        #1 w[j] = write_data;
        wt = h;
      end
      e = enc(eb[k], em[k], d, p);
      // First clock cell depends on history before the gate opened
      if (k == 0) w[15] = e[15];
      chk(w, e);
      p = eb[k][0];
    end
    chk(underrun, 1'b1);
    @(posedge clk) idx <= 1'b1;
    for (int i = 0; i < 20 && busy !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    chk({write_gate, busy, done}, 3'b001);
    @(posedge clk) idx <= 1'b0;
    eb.delete();
    em.delete();
  endtask
  task automatic t_reset();
    #1 chk({in_ready, write_gate, write_data, busy, underrun, done}, 6'h00);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    clk_en <= 1'b0;
    repeat (2) @(posedge clk);
    // Enable low must hold every flop, the FIFO's ready included
    #1 chk(in_ready, 1'b0);
    @(posedge clk) clk_en <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk(in_ready, 1'b1);
  endtask
  task automatic t_mfm();
    logic [7:0] s[16] = '{8'hf6, 8'hfc, 8'hf5, 8'hf5, 8'hf5, 8'hfe, 8'h00, 8'h01, 8'h05, 8'h01,
      8'hf7, 8'hf5, 8'hf5, 8'hf5, 8'hfb, 8'he5};
    foreach (s[i]) begin
      fw_host_i.send(s[i]);
      ex(s[i], 1'b1);
    end
    repeat (2) @(posedge clk);
    #1 chk(in_ready, 1'b0);
    eb.push_back(FILL_MFM);
    em.push_back(8'h00);
    run_track(1'b1);
  endtask
  // Stream opens without an index mark; one comes last only to check its clock pattern
  task automatic t_fm();
    logic [7:0] s[5] = '{8'hfe, 8'h00, 8'hf7, 8'hf5, 8'hfc};
    foreach (s[i]) begin
      fw_host_i.send(s[i]);
      ex(s[i], 1'b0);
    end
    eb.push_back(FILL_FM);
    em.push_back(8'h00);
    run_track(1'b0);
  endtask
  initial begin
    t_reset();
    t_mfm();
    t_fm();
    tally_and_finish();
  end
endmodule
